// file: oms_defines.svh
// Purpose: Offsets, codes and reset values for the operation mode selector
// Assumes: AXI4-Lite word registers, low byte used
// Notes:   Included by the selector and the testbench
`ifndef OMS_DEFINES_SVH
`define OMS_DEFINES_SVH
// ==========================================================================
// Register byte offsets
`define OMS_A_MODE 8'h00
`define OMS_A_START 8'h04
`define OMS_A_STOPL 8'h08
`define OMS_A_STAT 8'h0C
`define OMS_A_TERM0 8'h10
`define OMS_A_STEP 8'h04
// ==========================================================================
// Reset values
`define OMS_RV_MODE 3'h0
`define OMS_RV_START 4'h0
`define OMS_RV_STOPL 2'h0
`define OMS_RV_TERM 8'h00
// ==========================================================================
// Mode selection setting codes
`define OMS_MS_SW 3'h0
`define OMS_MS_PANEL 3'h1
`define OMS_MS_EXT 3'h2
`define OMS_MS_COMB3 3'h3
`define OMS_MS_COMB4 3'h4
`define OMS_MS_RUN 3'h6
`define OMS_MS_LOCK 3'h7
// ==========================================================================
// Startup mode setting codes
`define OMS_SU_ASSET 4'h0
`define OMS_SU_NET 4'h1
`define OMS_SU_NETPAN 4'hA
// Stop input logic code that inverts the interlock
`define OMS_SL_INV 2'h2
// ==========================================================================
// Terminal function codes
`define OMS_FN_LOCK 8'h0C
`define OMS_FN_PEXT 8'h10
`define OMS_FN_OSTOP 8'h18
`define OMS_FN_NP 8'h41
`define OMS_FN_NE 8'h42
// ==========================================================================
// Bus answers
`define OMS_RESP_OK 2'h0
`define OMS_RESP_ERR 2'h2
`endif

// file: oms_pkg.sv
// Purpose: Types of the operation mode selector
// Assumes: oms_defines.svh holds the numbers
// Notes:   Mode codes are Gray along EXT, PANEL, NET, COMB
package oms_pkg;
    // ======================================================================
    // Resolved operation mode
    typedef enum logic [1:0] {
        OMS_EXT = 2'h0,
        OMS_PANEL = 2'h1,
        OMS_NET = 2'h3,
        OMS_COMB = 2'h2
    } oms_mode_t;
    // ======================================================================
    // Filtered input terminal levels
    typedef struct packed {
        logic motor_stopped;
        logic fwd;
        logic rev;
        logic lock;
        logic ostop;
        logic pext;
        logic np;
        logic ne;
    } oms_pins_t;
endpackage

// file: oms_mode_selector.sv
// Purpose: Resolves the drive operation mode from settings and terminals
// Assumes: Terminal pins are asynchronous; settings reach us over AXI4-Lite
// Notes:   Mode re-evaluated every cycle from filtered inputs
//
// What this block does
// [RULE_01] Interlock on: refuse panel mode while any start is active; setting 1 still forces panel here.
// [RULE_02] Output-stop is interlock only while mode setting is 7.
// [RULE_03] Stop-input logic setting 2 inverts output-stop interlock polarity.
// [RULE_04] Panel/External switch changes mode only while drive is stopped, except with setting 6.
// [RULE_05] Panel/External switch works with setting 0, 6, 7; 6 also running.
// [RULE_06] Controller assigns function 16 to a terminal for panel/External.
// [RULE_07] Settings 0, 6, 7 (interlock on): switch on External, off panel.
// [RULE_08] Setting 1 panel, 2 External or network, 3 and 4 combined.
// [RULE_09] Setting 7: interlock off forces External; on permits switching.
// [RULE_10] Priority: setting, interlock, net/ext, net/panel, pext, startup.
// [RULE_11] Settings 0, 2, 6: network switches reach network when stopped.
// [RULE_12] Net/panel needs setting 0 or 6, startup 10, function 65.
// [RULE_13] Net/panel switch on gives panel, off gives network.
// [RULE_14] Net/panel on with net/External also on gives network.
// [RULE_15] Startup 10: no External via net/panel; off gives panel if pext off
// [RULE_16] Startup 10: setting 2 fixes network; 7 switches External/panel.
// [RULE_17] Net/External needs setting 0, 2, 6, 7, startup 0/1, function 66.
// [RULE_18] Net/External switch on gives network, off gives External.
// [RULE_19] Net/External off: panel if pext off, or follow net/panel switch.
// [RULE_20] Startup 0 or 1, setting 2: network or External only, never panel.
// [RULE_21] Setting 6: mode changes apply while the motor keeps running.
// [RULE_22] No interlock terminal, output-stop assigned, setting 7: it becomes interlock.
// [RULE_23] Resolved mode held as four-state code, re-evaluated each cycle.
`include "oms_defines.svh"

module oms_mode_selector import oms_pkg::*; #(
    parameter int AW = 8,
    parameter int TERMS = 5
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic motor_stopped_in,
    input wire logic forward_start_in,
    input wire logic reverse_start_in,
    input wire logic panel_interlock_in,
    input wire logic output_stop_in,
    input wire logic panel_ext_switch_in,
    input wire logic net_panel_switch_in,
    input wire logic net_ext_switch_in,
    output oms_mode_t mode_out,
    output logic output_stop_out,
    input wire logic [AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    // ======================================================================
    // Input synchronisers and agreement filter
    logic [7:0] pin_raw;
    logic [7:0] sy1_r;
    logic [7:0] sy2_r;
    logic [7:0] sy3_r;
    logic [7:0] filt_r;
    logic [7:0] filt_nxt;
    oms_pins_t pin;
    assign pin_raw = {motor_stopped_in, forward_start_in, reverse_start_in,
        panel_interlock_in, output_stop_in, panel_ext_switch_in,
        net_panel_switch_in, net_ext_switch_in};
    assign filt_nxt = (sy3_r & ~(sy2_r ^ sy3_r)) | (filt_r & (sy2_r ^ sy3_r));
    assign pin = oms_pins_t'(filt_r);
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            sy1_r <= 8'h00;
            sy2_r <= 8'h00;
            sy3_r <= 8'h00;
            filt_r <= 8'h00;
        end else begin
            sy1_r <= pin_raw;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            filt_r <= filt_nxt;
        end
    end

    // ======================================================================
    // Settings registers
    logic [2:0] msel_r;
    logic [3:0] start_r;
    logic [1:0] stopl_r;
    logic [7:0] term_r [TERMS];
    oms_mode_t mode_r;
    logic ostop_r;

    // ======================================================================
    // Terminal function assignment
    logic lk_asg;
    logic os_asg;
    logic px_asg;
    logic np_asg;
    logic ne_asg;
    always_comb begin
        lk_asg = 1'b0;
        os_asg = 1'b0;
        px_asg = 1'b0;
        np_asg = 1'b0;
        ne_asg = 1'b0;
        for (int i = 0; i < TERMS; i++) begin
            if (term_r[i] == `OMS_FN_LOCK) lk_asg = 1'b1;
            if (term_r[i] == `OMS_FN_OSTOP) os_asg = 1'b1;
            if (term_r[i] == `OMS_FN_PEXT) px_asg = 1'b1; // [RULE_06]
            if (term_r[i] == `OMS_FN_NP) np_asg = 1'b1; // [RULE_12]
            if (term_r[i] == `OMS_FN_NE) ne_asg = 1'b1; // [RULE_17]
        end
    end

    // ======================================================================
    // Interlock and output stop
    wire m7 = (msel_r == `OMS_MS_LOCK);
    wire ostop_is_lk = ~lk_asg & os_asg & m7; // [RULE_02] [RULE_22]
    wire os_inv = (stopl_r == `OMS_SL_INV);
    wire os_lvl = pin.ostop ^ os_inv; // [RULE_03]
    wire lk_on = lk_asg ? pin.lock : (ostop_is_lk & os_lvl);
    wire start_on = pin.fwd | pin.rev;
    wire stopped = pin.motor_stopped & ~start_on; // [RULE_04]
    wire ostop_nxt = (os_asg & ~ostop_is_lk & pin.ostop) |
        (m7 & lk_on & (mode_r == OMS_EXT)); // [RULE_09]

    // ======================================================================
    // Mode resolution
    wire px_on = px_asg & pin.pext;
    wire px_off = px_asg & ~pin.pext;
    wire np_on = np_asg & pin.np;
    wire ne_on = ne_asg & pin.ne;
    wire su10 = (start_r == `OMS_SU_NETPAN);
    wire su01 = (start_r == `OMS_SU_ASSET) | (start_r == `OMS_SU_NET);
    wire sw_set = (msel_r == `OMS_MS_SW) | (msel_r == `OMS_MS_RUN);
    wire comb = (msel_r == `OMS_MS_COMB3) | (msel_r == `OMS_MS_COMB4);
    wire m2 = (msel_r == `OMS_MS_EXT);
    wire m1 = (msel_r == `OMS_MS_PANEL);
    wire swable = sw_set | (m7 & lk_on); // [RULE_05] [RULE_07]
    wire force_sel = m1 | comb | (m7 & ~lk_on) | (m2 & su10); // [RULE_10]
    wire run_ok = (msel_r == `OMS_MS_RUN) | stopped; // [RULE_21]
    oms_mode_t tgt;
    always_comb begin
        tgt = mode_r;
        if (m1) begin
            tgt = OMS_PANEL; // [RULE_08]
        end else if (comb) begin
            tgt = OMS_COMB; // [RULE_08]
        end else if (m7 & ~lk_on) begin
            tgt = OMS_EXT; // [RULE_09]
        end else if (m2) begin
            if (su10) begin
                tgt = OMS_NET; // [RULE_16]
            end else if (ne_asg & su01) begin
                tgt = ne_on ? OMS_NET : OMS_EXT; // [RULE_20] [RULE_11]
            end else begin
                tgt = OMS_EXT;
            end
        end else if (swable) begin
            if (ne_asg & su01) begin
                if (ne_on) begin
                    tgt = OMS_NET; // [RULE_18]
                end else if (np_asg) begin
                    tgt = np_on ? OMS_PANEL : OMS_EXT; // [RULE_19]
                end else begin
                    tgt = px_off ? OMS_PANEL : OMS_EXT; // [RULE_19]
                end
            end else if (su10 & sw_set & np_asg) begin
                if (np_on) begin
                    tgt = ne_on ? OMS_NET : OMS_PANEL; // [RULE_13] [RULE_14]
                end else begin
                    tgt = px_off ? OMS_PANEL : OMS_NET; // [RULE_15]
                end
            end else if (px_asg) begin
                tgt = px_on ? OMS_EXT : OMS_PANEL; // [RULE_07] [RULE_16]
            end
        end
    end
    wire panel_block = lk_on & start_on & (tgt == OMS_PANEL); // [RULE_01]
    oms_mode_t mode_nxt;
    assign mode_nxt = force_sel ? tgt :
        ((run_ok & ~panel_block) ? tgt : mode_r); // [RULE_04] [RULE_11]
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mode_r <= OMS_EXT;
            ostop_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt; // [RULE_23]
            ostop_r <= ostop_nxt;
        end
    end
    assign mode_out = mode_r;
    assign output_stop_out = ostop_r;

    // ======================================================================
    // AXI4-Lite write channel
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [AW-1:0] wa_r;
    logic [31:0] wd_r;
    logic ws_r;
    wire aw_take = s_axi_awvalid_in & awready_r;
    wire w_take = s_axi_wvalid_in & wready_r;
    wire do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
    wire aw_hold_nxt = ~do_wr & (aw_hold_r | aw_take);
    wire w_hold_nxt = ~do_wr & (w_hold_r | w_take);
    wire wr_mode = (wa_r == `OMS_A_MODE);
    wire wr_start = (wa_r == `OMS_A_START);
    wire wr_stopl = (wa_r == `OMS_A_STOPL);
    wire wr_stat = (wa_r == `OMS_A_STAT);
    logic [TERMS-1:0] wr_term;
    always_comb begin
        wr_term = '0;
        for (int i = 0; i < TERMS; i++) begin
            wr_term[i] = (wa_r == AW'(`OMS_A_TERM0 + i * `OMS_A_STEP));
        end
    end
    wire wr_hit = wr_mode | wr_start | wr_stopl | wr_stat | (|wr_term);
    wire wr_en = do_wr & ws_r;
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `OMS_RESP_OK;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            wa_r <= '0;
            wd_r <= 32'h0000_0000;
            ws_r <= 1'b0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awready_r <= ~aw_hold_nxt;
            wready_r <= ~w_hold_nxt;
            if (aw_take) wa_r <= s_axi_awaddr_in;
            if (w_take) wd_r <= s_axi_wdata_in;
            if (w_take) ws_r <= s_axi_wstrb_in[0];
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `OMS_RESP_OK : `OMS_RESP_ERR;
            end else if (s_axi_bready_in) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            msel_r <= `OMS_RV_MODE;
            start_r <= `OMS_RV_START;
            stopl_r <= `OMS_RV_STOPL;
            for (int i = 0; i < TERMS; i++) term_r[i] <= `OMS_RV_TERM;
        end else begin
            if (wr_en & wr_mode) msel_r <= wd_r[2:0];
            if (wr_en & wr_start) start_r <= wd_r[3:0];
            if (wr_en & wr_stopl) stopl_r <= wd_r[1:0];
            for (int i = 0; i < TERMS; i++) begin
                if (wr_en & wr_term[i]) term_r[i] <= wd_r[7:0];
            end
        end
    end
    assign s_axi_awready_out = awready_r;
    assign s_axi_wready_out = wready_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;

    // ======================================================================
    // AXI4-Lite read channel
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] rd_mux;
    logic rd_hit;
    wire ar_take = s_axi_arvalid_in & arready_r;
    wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_in);
    wire [31:0] stat_word = {24'h000000, lk_on, start_on, stopped,
        ostop_is_lk, ostop_r, 1'b0, mode_r};
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        if (s_axi_araddr_in == `OMS_A_MODE) begin
            rd_mux = {29'h0000_0000, msel_r};
        end else if (s_axi_araddr_in == `OMS_A_START) begin
            rd_mux = {28'h000_0000, start_r};
        end else if (s_axi_araddr_in == `OMS_A_STOPL) begin
            rd_mux = {30'h0000_0000, stopl_r};
        end else if (s_axi_araddr_in == `OMS_A_STAT) begin
            rd_mux = stat_word;
        end else begin
            rd_hit = 1'b0;
        end
        for (int i = 0; i < TERMS; i++) begin
            if (s_axi_araddr_in == AW'(`OMS_A_TERM0 + i * `OMS_A_STEP)) begin
                rd_mux = {24'h000000, term_r[i]};
                rd_hit = 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `OMS_RESP_OK;
        end else begin
            rvalid_r <= rvalid_nxt;
            arready_r <= ~rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? `OMS_RESP_OK : `OMS_RESP_ERR;
            end
        end
    end
    assign s_axi_arready_out = arready_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;

    // ======================================================================
    // Assertions
    no_panel_start_a: assert property (@(posedge sys_clk_in) // [RULE_01]
        disable iff (sys_rst_in)
        lk_on && start_on && mode_r != OMS_PANEL |=> mode_r != OMS_PANEL)
        else $error("panel mode entered with start active");
    ostop_role_a: assert property (@(posedge sys_clk_in) // [RULE_02]
        disable iff (sys_rst_in)
        ostop_is_lk |-> m7 && !lk_asg && os_asg)
        else $error("output stop acts as interlock outside setting 7");
    ostop_pol_a: assert property (@(posedge sys_clk_in) // [RULE_03]
        disable iff (sys_rst_in)
        ostop_is_lk |-> lk_on == (pin.ostop ^ (stopl_r == `OMS_SL_INV)))
        else $error("interlock polarity wrong");
    stop_gate_a: assert property (@(posedge sys_clk_in) // [RULE_04]
        disable iff (sys_rst_in)
        msel_r == `OMS_MS_SW && !stopped ##1 msel_r == `OMS_MS_SW
        |-> $stable(mode_r))
        else $error("mode changed while running");
    fixed_panel_a: assert property (@(posedge sys_clk_in) // [RULE_08]
        disable iff (sys_rst_in)
        m1 [*2] |-> mode_r == OMS_PANEL)
        else $error("setting 1 not panel");
    comb_fixed_a: assert property (@(posedge sys_clk_in) // [RULE_08]
        disable iff (sys_rst_in)
        comb |=> mode_r == OMS_COMB)
        else $error("settings 3 and 4 not combined");
    forced_ext_a: assert property (@(posedge sys_clk_in) // [RULE_09]
        disable iff (sys_rst_in)
        m7 && !lk_on |=> mode_r == OMS_EXT)
        else $error("interlock off did not force External");
    net_fixed_a: assert property (@(posedge sys_clk_in) // [RULE_16]
        disable iff (sys_rst_in)
        m2 && su10 |=> mode_r == OMS_NET)
        else $error("setting 2 with startup 10 not network");
    no_panel_m2_a: assert property (@(posedge sys_clk_in) // [RULE_20]
        disable iff (sys_rst_in)
        m2 && su01 && mode_r != OMS_PANEL |=> mode_r != OMS_PANEL)
        else $error("panel reached with setting 2");
    run_switch_a: assert property (@(posedge sys_clk_in) // [RULE_21]
        disable iff (sys_rst_in)
        msel_r == `OMS_MS_RUN && !panel_block |=> mode_r == $past(tgt))
        else $error("switchover not applied while running");
endmodule

// file: oms_pin_model.sv
// Purpose: Behavioural terminal driver standing in for outside switches
// Assumes: Bench sets wanted levels; pins follow one clock later
// Notes:   Levels held steady between bench changes, no bounce
module oms_pin_model import oms_pkg::*; (
    input wire logic sys_clk_in,
    input wire oms_pins_t want_in,
    output oms_pins_t pins_out
);
    // ======================================================================
    // Terminal levels; the bench assigns functions 12, 16, 24, 65 and 66
    always_ff @(posedge sys_clk_in) begin
        pins_out <= want_in;
    end
endmodule

// file: oms_mode_selector_tb.sv
// Purpose: Self-checking bench for the operation mode selector
// Assumes: Pin change shows in mode within 5 edges of the pin model
// Notes:   Settings reach the block over AXI4-Lite tasks
`include "oms_defines.svh"
module oms_mode_selector_tb import oms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================================
    // Signals
    logic clk = 0, rst = 1;
    oms_pins_t want = '0, pins;
    oms_mode_t mode;
    logic ostop_out;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs, bs;
    int bad_count = 0, n_compared = 0;
    initial forever #4 clk = ~clk;
    oms_pin_model pm_u (.sys_clk_in(clk), .want_in(want), .pins_out(pins));
    oms_mode_selector dut_u (.sys_clk_in(clk), .sys_rst_in(rst),
        .motor_stopped_in(pins.motor_stopped), .forward_start_in(pins.fwd),
        .reverse_start_in(pins.rev), .panel_interlock_in(pins.lock),
        .output_stop_in(pins.ostop), .panel_ext_switch_in(pins.pext),
        .net_panel_switch_in(pins.np), .net_ext_switch_in(pins.ne),
        .mode_out(mode), .output_stop_out(ostop_out),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready));
    // ======================================================================
    // Report and checks
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic cm(input oms_mode_t e);
        repeat (8) @(posedge clk);
        chk("mode", {30'h0, e}, {30'h0, mode});
    endtask
    // ======================================================================
    // AXI4-Lite master: handshakes sampled and acted on at the rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hF);
        logic b_ok;
        int n;
        n = 0;
        b_ok = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_ok && n < 50) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            b_ok = bvalid && bready;
            bs = bresp;
            n++;
        end
        bready <= 1'b0;
        if (!b_ok) begin
            bad_count++;
            $display("ERROR write answer expected 1 seen 0");
            finish_test();
        end
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a);
        logic r_ok;
        int n;
        n = 0;
        r_ok = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_ok && n < 50) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            r_ok = rvalid && rready;
            rd = rdata;
            rs = rresp;
            n++;
        end
        rready <= 1'b0;
        if (!r_ok) begin
            bad_count++;
            $display("ERROR read answer expected 1 seen 0");
            finish_test();
        end
        @(posedge clk);
    endtask
    // ======================================================================
    // Tests
    initial begin
        want.motor_stopped <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axr(`OMS_A_MODE);
        chk("mode reg", 32'h0, rd);
        axr(8'h40);
        chk("rresp", {30'h0, `OMS_RESP_ERR}, {30'h0, rs});
        axw(8'h40, 32'h1);
        chk("bresp", {30'h0, `OMS_RESP_ERR}, {30'h0, bs});
        axw(`OMS_A_MODE, 32'h1, 4'h0);
        chk("bresp strobe", {30'h0, `OMS_RESP_OK}, {30'h0, bs});
        axr(`OMS_A_MODE);
        chk("strobe off", 32'h0, rd);
        $display("test bus done");
        axw(`OMS_A_TERM0 + 8'h04, 32'h10);
        cm(OMS_PANEL);
        want.pext <= 1'b1;
        cm(OMS_EXT);
        want.motor_stopped <= 1'b0;
        want.pext <= 1'b0;
        cm(OMS_EXT);
        axw(`OMS_A_MODE, 32'h6);
        cm(OMS_PANEL);
        want.pext <= 1'b1;
        cm(OMS_EXT);
        want.motor_stopped <= 1'b1;
        for (int i = 1; i < 5; i++) begin
            axw(`OMS_A_MODE, i);
            cm(i == 1 ? OMS_PANEL : i == 2 ? OMS_EXT : OMS_COMB);
        end
        $display("test fixed done");
        axw(`OMS_A_TERM0 + 8'h0C, 32'h42);
        axw(`OMS_A_MODE, 32'h0);
        want.pext <= 1'b0;
        want.ne <= 1'b1;
        cm(OMS_NET);
        want.ne <= 1'b0;
        cm(OMS_PANEL);
        axw(`OMS_A_MODE, 32'h2);
        cm(OMS_EXT);
        want.ne <= 1'b1;
        cm(OMS_NET);
        want.motor_stopped <= 1'b0;
        want.ne <= 1'b0;
        cm(OMS_NET);
        want.motor_stopped <= 1'b1;
        cm(OMS_EXT);
        $display("test net ext done");
        axw(`OMS_A_START, 32'hA);
        axw(`OMS_A_MODE, 32'h0);
        axw(`OMS_A_TERM0 + 8'h08, 32'h41);
        want.np <= 1'b1;
        cm(OMS_PANEL);
        want.ne <= 1'b1;
        cm(OMS_NET);
        want.ne <= 1'b0;
        want.np <= 1'b0;
        cm(OMS_PANEL);
        want.pext <= 1'b1;
        cm(OMS_NET);
        axw(`OMS_A_MODE, 32'h2);
        cm(OMS_NET);
        $display("test net panel done");
        axw(`OMS_A_START, 32'h0);
        axw(`OMS_A_TERM0 + 8'h08, 32'h0);
        axw(`OMS_A_TERM0 + 8'h0C, 32'h0);
        axw(`OMS_A_TERM0, 32'h0C);
        axw(`OMS_A_MODE, 32'h7);
        want.pext <= 1'b0;
        cm(OMS_EXT);
        want.lock <= 1'b1;
        cm(OMS_PANEL);
        want.pext <= 1'b1;
        cm(OMS_EXT);
        chk("output stop", 32'h1, {31'h0, ostop_out});
        axr(`OMS_A_STAT);
        chk("status", 32'hA8, rd);
        axw(`OMS_A_MODE, 32'h6);
        want.fwd <= 1'b1;
        want.pext <= 1'b0;
        cm(OMS_EXT);
        want.fwd <= 1'b0;
        cm(OMS_PANEL);
        $display("test interlock done");
        axw(`OMS_A_TERM0, 32'h0);
        axw(`OMS_A_TERM0 + 8'h10, 32'h18);
        axw(`OMS_A_MODE, 32'h7);
        want.lock <= 1'b0;
        cm(OMS_EXT);
        want.ostop <= 1'b1;
        cm(OMS_PANEL);
        axw(`OMS_A_STOPL, 32'h2);
        cm(OMS_EXT);
        want.ostop <= 1'b0;
        cm(OMS_PANEL);
        axw(`OMS_A_STOPL, 32'h0);
        want.ostop <= 1'b1;
        axw(`OMS_A_MODE, 32'h0);
        cm(OMS_PANEL);
        chk("plain stop", 32'h1, {31'h0, ostop_out});
        $display("test output stop done");
        finish_test();
    end
endmodule
